// ### design/rlt_timer_bank.sv
// Bank of reloadable 16-bit countdown timers with a shared status,
// clear and enable register set and one level interrupt.
// Assumes the register master and the clock enable share i_mclk.
//
// Summary of operation
// - Six channels, each with own counter, mode, prescaler and control.
// - Each channel counts its 16-bit counter down by one per tick.
// - Tick comes from a 4-bit prescaler tapped at divide 2, 4, 8 or 16.
// - Each channel runs either single-pass or continuous.
// - Software starts, stops, resumes, or restarts from the reload value.
`timescale 1ns/1ps
`default_nettype none

module rlt_timer_bank
  import rlt_pkg::*;
#(
  parameter int NUM_CH = 6
) (
  input  wire logic              i_mclk,
  input  wire logic              i_reset,
  input  wire logic              i_ce,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output var  logic [DATA_W-1:0] o_rdata,
  output var  logic              o_irq
);

  // Channel address field is 3 bits and the bank registers start at 0x18
  if (NUM_CH < 1 || NUM_CH > 6) begin : g_bad_num_ch
    $error("rlt_timer_bank: NUM_CH must lie in 1..6");
  end

  function automatic logic [ADDR_W-1:0] reg_addr(input int ch,
                                                 input logic [1:0] off);
    reg_addr = {3'(ch), off};
  endfunction

  function automatic logic tap_hit(input logic [PRE_W-1:0] pre,
                                   input rlt_div_type sel);
    case (sel)
      RLT_DIV2:  tap_hit = pre[0];
      RLT_DIV4:  tap_hit = &pre[1:0];
      RLT_DIV8:  tap_hit = &pre[2:0];
      default:   tap_hit = &pre;
    endcase
  endfunction

  rlt_ctl_type              ctl_r    [NUM_CH];
  rlt_ctl_type              ctl_nxt  [NUM_CH];
  logic [CNT_W-1:0]         reload_r [NUM_CH];
  logic [CNT_W-1:0]         reload_nxt [NUM_CH];
  logic [CNT_W-1:0]         count_r  [NUM_CH];
  logic [CNT_W-1:0]         count_nxt [NUM_CH];
  logic [PRE_W-1:0]         pre_r    [NUM_CH];
  logic [PRE_W-1:0]         pre_nxt  [NUM_CH];
  logic [NUM_CH-1:0]        tick;
  logic [NUM_CH-1:0]        evt;
  logic [NUM_CH-1:0]        status_r;
  logic [NUM_CH-1:0]        status_nxt;
  logic [NUM_CH-1:0]        enable_r;
  logic [NUM_CH-1:0]        enable_nxt;
  logic [NUM_CH-1:0]        clear;
  logic [DATA_W-1:0]        rdata_nxt;
  logic                     irq_nxt;
  logic [2:0]               rd_ch;

  // Channel state
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      ctl_nxt[k] = ctl_r[k];
      reload_nxt[k] = reload_r[k];
      count_nxt[k] = count_r[k];
      pre_nxt[k] = pre_r[k];
      tick[k] = i_ce && ctl_r[k].run && tap_hit(pre_r[k], ctl_r[k].psel);
      evt[k] = tick[k] && (count_r[k] <= CNT_W'(1));
      // Prescaler only advances while the channel runs, so stop and
      // resume keep the phase of the current tick
      if (ctl_r[k].run) begin
        pre_nxt[k] = pre_r[k] + PRE_W'(1);
      end
      if (evt[k]) begin
        if (ctl_r[k].cont) begin
          count_nxt[k] = reload_r[k];
        end else begin
          count_nxt[k] = COUNT_RST;
          ctl_nxt[k].run = 1'b0;
        end
      end else if (tick[k]) begin
        count_nxt[k] = count_r[k] - CNT_W'(1);
      end
      // Software wins over a same-cycle hardware stop or reload
      if (i_wr && i_addr == reg_addr(k, OFF_CTRL)) begin
        ctl_nxt[k] = rlt_ctl_type'(i_wdata[CTL_FIELD_W-1:0]);
        if (i_wdata[CTL_RESTART_BIT]) begin
          count_nxt[k] = reload_r[k];
          pre_nxt[k] = PRE_RST;
        end
      end
      if (i_wr && i_addr == reg_addr(k, OFF_RELOAD)) begin
        reload_nxt[k] = i_wdata[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      for (int k = 0; k < NUM_CH; k++) begin
        ctl_r[k] <= CTL_RST;
        reload_r[k] <= RELOAD_RST;
        count_r[k] <= COUNT_RST;
        pre_r[k] <= PRE_RST;
      end
    end else if (i_ce) begin
      for (int k = 0; k < NUM_CH; k++) begin
        ctl_r[k] <= ctl_nxt[k];
        reload_r[k] <= reload_nxt[k];
        count_r[k] <= count_nxt[k];
        pre_r[k] <= pre_nxt[k];
      end
    end
  end

  // Status, interrupt and read data
  always_comb begin
    clear = '0;
    enable_nxt = enable_r;
    if (i_wr && i_addr == ADDR_CLEAR) begin
      clear = i_wdata[NUM_CH-1:0];
    end else if (i_wr && i_addr == ADDR_ENABLE) begin
      enable_nxt = i_wdata[NUM_CH-1:0];
    end
    // A new end-of-count beats a clear in the same cycle
    status_nxt = (status_r & ~clear) | evt;
    irq_nxt = |(status_nxt & enable_nxt);
    rd_ch = i_addr[ADDR_W-1:2];
    rdata_nxt = '0;
    if (!i_rd) begin
      rdata_nxt = '0;
    end else if (i_addr == ADDR_STATUS) begin
      rdata_nxt = DATA_W'(status_r);
    end else if (i_addr == ADDR_ENABLE) begin
      rdata_nxt = DATA_W'(enable_r);
    end else if (int'(rd_ch) < NUM_CH && i_addr[1:0] == OFF_CTRL) begin
      rdata_nxt = DATA_W'(ctl_r[rd_ch]);
    end else if (int'(rd_ch) < NUM_CH && i_addr[1:0] == OFF_RELOAD) begin
      rdata_nxt = reload_r[rd_ch];
    end else if (int'(rd_ch) < NUM_CH && i_addr[1:0] == OFF_COUNT) begin
      rdata_nxt = count_r[rd_ch];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      status_r <= '0;
      enable_r <= '0;
      o_irq <= 1'b0;
      o_rdata <= '0;
    end else if (i_ce) begin
      status_r <= status_nxt;
      enable_r <= enable_nxt;
      o_irq <= irq_nxt;
      o_rdata <= rdata_nxt;
    end
  end

  // Checks on channel 0, with channel 1 as the bystander
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence s_ctl0_write;
    i_ce && i_wr && i_addr == reg_addr(0, OFF_CTRL);
  endsequence

  sequence s_end0;
    i_ce && evt[0] && !(i_wr && i_addr == reg_addr(0, OFF_CTRL));
  endsequence

  property p_isolated;
    (i_ce && i_wr && i_addr == reg_addr(0, OFF_RELOAD))
      |=> $stable(reload_r[1]) && reload_r[0] == $past(i_wdata);
  endproperty
  a_isolated: assert property (p_isolated)
    else $error("reload leaked");

  property p_decrement;
    (i_ce && tick[0] && count_r[0] > CNT_W'(1) && !i_wr)
      |=> count_r[0] == $past(count_r[0]) - CNT_W'(1);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("no decrement");

  property p_div16_gap;
    // Software may retune the tap inside the gap; only divide-by-16 is held
    (tick[0] && ctl_r[0].psel == RLT_DIV16)
      |=> (!tick[0] || ctl_r[0].psel != RLT_DIV16) [*8];
  endproperty
  a_div16_gap: assert property (p_div16_gap)
    else $error("tick too early");

  property p_single_stops;
    (s_end0 and (ctl_r[0].cont == 1'b0)) |=> !ctl_r[0].run && !tick[0];
  endproperty
  a_single_stops: assert property (p_single_stops)
    else $error("no stop");

  property p_cont_reloads;
    (s_end0 and ctl_r[0].cont) |=> ctl_r[0].run
      && count_r[0] == $past(reload_r[0]) && status_r[0];
  endproperty
  a_cont_reloads: assert property (p_cont_reloads)
    else $error("no reload");

  property p_hold_stopped;
    (i_ce && !ctl_r[0].run && !i_wr) |=> $stable(count_r[0]);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped)
    else $error("count moved");

  property p_restart;
    (s_ctl0_write and i_wdata[CTL_RESTART_BIT])
      |=> count_r[0] == $past(reload_r[0]);
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart failed");

  property p_irq;
    (i_ce && evt[0] && enable_r[0] && !i_wr) |=> status_r[0] && o_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("event lost");

endmodule

`default_nettype wire

// ### design/rlt_pkg.sv
// Shared constants and types for the reloadable countdown timer bank.
// Assumes a single clock domain and a plain strobe register port.
package rlt_pkg;

  localparam int CNT_W = 16;
  localparam int PRE_W = 4;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Per channel register offsets; channel k sits at word address 4*k + off
  localparam logic [1:0] OFF_CTRL = 2'h0;
  localparam logic [1:0] OFF_RELOAD = 2'h1;
  localparam logic [1:0] OFF_COUNT = 2'h2;

  // Bank wide registers
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h18;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR = 5'h19;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 5'h1A;

  // Control word fields
  localparam int CTL_FIELD_W = 4;
  localparam int CTL_RESTART_BIT = 4;

  // Reset values
  localparam logic [CNT_W-1:0] RELOAD_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [PRE_W-1:0] PRE_RST = 4'h0;

  // Prescaler tap: divide by 2, 4, 8 or 16
  typedef enum logic [1:0] {
    RLT_DIV2  = 2'b00,
    RLT_DIV4  = 2'b01,
    RLT_DIV8  = 2'b10,
    RLT_DIV16 = 2'b11
  } rlt_div_type;

  // Bit 0 run, bit 1 continuous, bits 3:2 prescaler tap
  typedef struct packed {
    rlt_div_type psel;
    logic        cont;
    logic        run;
  } rlt_ctl_type;

  localparam rlt_ctl_type CTL_RST = '{psel: RLT_DIV2, cont: 1'b0,
                                      run: 1'b0};

endpackage

// ### verification/testbench.sv
// Self-checking bench for the reloadable countdown timer bank.
// Assumes the register map and reset values of rlt_pkg.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rlt_pkg::*;
  logic              i_mclk;
  logic              i_reset;
  logic              i_ce;
  logic              i_wr;
  logic              i_rd;
  logic              o_irq;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic [DATA_W-1:0] o_rdata;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] c;
  logic [DATA_W-1:0] rl;
  int                miscompares;
  int                n_compared;
  int                p;

  rlt_timer_bank u_rlt_timer_bank (
    .i_mclk (i_mclk),
    .i_reset(i_reset),
    .i_ce   (i_ce),
    .i_addr (i_addr),
    .i_wdata(i_wdata),
    .i_wr   (i_wr),
    .i_rd   (i_rd),
    .o_rdata(o_rdata),
    .o_irq  (o_irq)
  );

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Both tasks start and end just after a rising edge
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic rd(input logic [4:0] a);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
    @(posedge i_mclk);
  endtask

  function automatic logic [15:0] exp_cnt(int r, int j, bit cont);
    if (cont) return 16'(r - j % r);
    return (j >= r) ? 16'h0000 : 16'(r - j);
  endfunction

  task automatic final_report;
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    miscompares++;
    final_report();
  end

  initial begin
    void'($urandom(14095));
    i_reset = 1'b1;
    i_ce    = 1'b1;
    i_wr    = 1'b0;
    i_rd    = 1'b0;
    i_addr  = '0;
    i_wdata = '0;
    repeat (20) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    rd(5'h00);
    chk("ctrl", d, 16'h0000);
    rd(5'h01);
    chk("reload", d, 16'hFFFF);
    rd(5'h1F);
    chk("unmapped", d, 16'h0000);
    chk("irq", 16'(o_irq), 16'h0000);
    wr(ADDR_ENABLE, 16'h003F);
    // Channels 0..3 continuous on each tap, channel 4 single-pass
    for (int t = 0; t < 5; t++) begin
      p  = 2 << (t % 4);
      rl = 16'(3 + $urandom % 5);
      wr(5'(4 * t + 1), rl);
      wr(5'(4 * t), 16'(16'h11 | (t < 4 ? 2 : 0) | ((t % 4) << 2)));
      repeat ((rl + 1) * p + p / 2 - 1) @(posedge i_mclk);
      rd(5'(4 * t + 2));
      chk("count", d, exp_cnt(rl, rl + 1, t < 4));
    end
    rd(5'h10);
    chk("ctrl4", d, 16'h0000);
    rd(5'h16);
    chk("count5", d, 16'h0000);
    rd(ADDR_STATUS);
    chk("status", d, 16'h001F);
    chk("irq", 16'(o_irq), 16'h0001);
    wr(ADDR_ENABLE, 16'h0000);
    rd(ADDR_ENABLE);
    chk("enable", d, 16'h0000);
    chk("irq", 16'(o_irq), 16'h0000);
    for (int t = 0; t < 4; t++) wr(5'(4 * t), 16'h0000);
    wr(ADDR_CLEAR, 16'h003F);
    rd(ADDR_STATUS);
    chk("status", d, 16'h0000);
    // Stop holds the count, resume goes on, restart reloads
    rl = 16'(16'h0100 + $urandom % 256);
    wr(5'h15, rl);
    wr(5'h14, 16'h0013);
    repeat (10) @(posedge i_mclk);
    wr(5'h14, 16'h0002);
    rd(5'h16);
    c = d;
    repeat (10) @(posedge i_mclk);
    rd(5'h16);
    chk("held", d, c);
    wr(5'h14, 16'h0003);
    repeat (10) @(posedge i_mclk);
    rd(5'h16);
    chk("resumed", 16'(d < c), 16'h0001);
    wr(5'h14, 16'h0012);
    rd(5'h16);
    chk("restart", d, rl);
    // Clock enable low for 20 edges: only the two enabled edges count
    wr(5'h14, 16'h0003);
    rd(5'h16);
    c = d;
    i_ce <= 1'b0;
    repeat (20) @(posedge i_mclk);
    i_ce <= 1'b1;
    rd(5'h16);
    chk("frozen", d, c - 16'h0001);
    // Reset in mid-run brings back the reload value and stops the channel
    i_reset <= 1'b1;
    @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    rd(5'h15);
    chk("reload5", d, 16'hFFFF);
    rd(5'h14);
    chk("ctrl5", d, 16'h0000);
    // Channel 0 single-pass on divide-by-16: one tick after 20 cycles
    wr(ADDR_ENABLE, 16'h0001);
    wr(5'h01, 16'h0002);
    wr(5'h00, 16'h001D);
    repeat (20) @(posedge i_mclk);
    rd(5'h02);
    chk("count0", d, 16'h0001);
    repeat (20) @(posedge i_mclk);
    rd(5'h00);
    chk("ctrl0", d, 16'h000C);
    rd(5'h02);
    chk("count0", d, 16'h0000);
    rd(ADDR_STATUS);
    chk("status", d, 16'h0001);
    chk("irq", 16'(o_irq), 16'h0001);
    final_report();
  end
endmodule
`default_nettype wire
